// >>> src/wdk_defines.svh
`ifndef WDK_DEFINES_SVH
`define WDK_DEFINES_SVH

// service key value
`define WDK_KEY 8'hA5
// register word offsets (byte addresses)
`define WDK_OFS_SERVICE 4'h0
`define WDK_OFS_CTRL 4'h4
`define WDK_OFS_CLOSED 4'h8
`define WDK_OFS_OPEN 4'hC
`define WDK_OFS_STATUS 4'h0
// ctrl fields
`define WDK_CTRL_EN 0
`define WDK_CTRL_WIN 1
// reset values
`define WDK_SERVICE_RST 8'h00
`define WDK_CLOSED_RST 32'h0000_0100
`define WDK_OPEN_RST 32'h0000_1000
// system reset pulse length in clocks
`define WDK_RST_PULSE 4'h8

`endif

// >>> src/wdk_pkg.sv
package wdk_pkg;
   // watchdog phase
   typedef enum logic [1:0]
   {
      WDK_IDLE = 2'b00,
      WDK_CLOSED = 2'b01,
      WDK_OPEN = 2'b10
   } wdk_phase_e;

   // classic wishbone request from the master
   typedef struct packed
   {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [3:0] adr;
      logic [31:0] dat;
   } wdk_wb_req_s;

   // slave answer
   typedef struct packed
   {
      logic ack;
      logic [31:0] dat;
   } wdk_wb_rsp_s;
endpackage

// >>> src/wdk_timer.sv
`timescale 1ns/10ps
`include "wdk_defines.svh"
// phase counter: runs closed period (window mode only) then open period, flags expiry
module wdk_timer
#(
   parameter int CW = 32
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic enable,
   input wire logic window_mode,
   input wire logic restart,
   input wire logic [CW-1:0] closed_len,
   input wire logic [CW-1:0] open_len,
   output wdk_pkg::wdk_phase_e phase,
   output logic expired
);
   import wdk_pkg::*;

   // refuse widths at elaboration; no runtime check is left behind
   if (CW < 2 || CW > 32)
   begin
      $error("wdk_timer: counter width out of range");
   end

   wdk_phase_e phase_reg;
   logic [CW-1:0] cnt_reg; // cycles left in current phase
   logic expired_reg; // one-cycle expiry pulse

   assign phase = phase_reg;
   assign expired = expired_reg;

   // phase sequencing; restart always reopens from the start
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         phase_reg <= WDK_IDLE;
         cnt_reg <= '0;
         expired_reg <= 1'b0;
      end
      else
      begin
         expired_reg <= 1'b0;
         if (!enable)
         begin
            phase_reg <= WDK_IDLE;
            cnt_reg <= '0;
         end
         else if (restart || phase_reg == WDK_IDLE)
         begin
            // window mode starts with the closed period
            if (window_mode)
            begin
               phase_reg <= WDK_CLOSED;
               cnt_reg <= closed_len;
            end
            else
            begin
               phase_reg <= WDK_OPEN;
               cnt_reg <= open_len;
            end
         end
         else if (cnt_reg > 1)
            cnt_reg <= cnt_reg - 1'b1;
         else
         begin
            case (phase_reg)
               WDK_CLOSED:
               begin
                  phase_reg <= WDK_OPEN;
                  cnt_reg <= open_len;
               end
               WDK_OPEN:
               begin
                  // expiry restarts the sequence; reset is issued
                  expired_reg <= 1'b1;
                  phase_reg <= WDK_IDLE;
               end
               default:
                  phase_reg <= WDK_IDLE;
            endcase
         end
      end
   end
endmodule

// >>> src/wdk_service.sv
`timescale 1ns/10ps
`include "wdk_defines.svh"
// watchdog service-key decode with wishbone register access
module wdk_service
#(
   parameter int CW = 32
)
(
   input wire logic clk,
   input wire logic resetn,
   input wdk_pkg::wdk_wb_req_s wb_req,
   output wdk_pkg::wdk_wb_rsp_s wb_rsp,
   output logic sys_reset
);
   import wdk_pkg::*;

   // the length registers must hold their reset values without loss
   if (CW < 13 || CW > 32)
   begin
      $error("wdk_service: counter width out of range");
   end

   logic ack_reg; // bus acknowledge
   logic [31:0] rdat_reg; // read data
   logic en_reg; // watchdog enable
   logic win_reg; // window mode select
   logic [CW-1:0] closed_reg; // closed period length
   logic [CW-1:0] open_reg; // open period length
   logic [7:0] service_reg; // last key written
   logic restart_reg; // counter restart pulse
   logic [3:0] rst_cnt_reg; // system reset pulse stretch
   logic sys_reset_reg;
   logic [1:0] last_cause_reg; // 1 bad key, 2 closed write, 3 expiry
   wdk_phase_e phase;
   logic expired;
   logic access;
   logic svc_write;
   logic key_ok;
   logic bad_write;

   assign wb_rsp.ack = ack_reg;
   assign wb_rsp.dat = rdat_reg;
   assign sys_reset = sys_reset_reg;

   // one-cycle-wait classic slave: ack after one clock
   assign access = wb_req.cyc && wb_req.stb && !ack_reg;
   assign svc_write = access && wb_req.we &&
      wb_req.adr == `WDK_OFS_SERVICE && wb_req.sel[0] && en_reg;
   assign key_ok = wb_req.dat[7:0] == `WDK_KEY;
   // any service write in closed window, or a wrong key, is fatal
   assign bad_write = svc_write &&
      (!key_ok || (win_reg && phase == WDK_CLOSED));

   wdk_timer #(.CW(CW)) u_timer
   (
      .clk(clk),
      .resetn(resetn),
      .enable(en_reg),
      .window_mode(win_reg),
      .restart(restart_reg),
      .closed_len(closed_reg),
      .open_len(open_reg),
      .phase(phase),
      .expired(expired)
   );

   // bus handshake and read mux
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= access;
         rdat_reg <= 32'h0000_0000;
         // service register is write-only; its offset reads status (last cause, phase)
         if (access && !wb_req.we)
         begin
            case (wb_req.adr)
               `WDK_OFS_CTRL:
                  rdat_reg <= {30'h0, win_reg, en_reg};
               `WDK_OFS_CLOSED:
                  rdat_reg <= 32'(closed_reg);
               `WDK_OFS_OPEN:
                  rdat_reg <= 32'(open_reg);
               default:
                  rdat_reg <= {28'h0, last_cause_reg, 2'(phase)};
            endcase
         end
      end
   end

   // configuration writes; locked settings are not modelled
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         en_reg <= 1'b0;
         win_reg <= 1'b0;
         closed_reg <= CW'(`WDK_CLOSED_RST);
         open_reg <= CW'(`WDK_OPEN_RST);
      end
      else if (access && wb_req.we && wb_req.sel[0])
      begin
         case (wb_req.adr)
            `WDK_OFS_CTRL:
            begin
               en_reg <= wb_req.dat[`WDK_CTRL_EN];
               win_reg <= wb_req.dat[`WDK_CTRL_WIN];
            end
            `WDK_OFS_CLOSED:
               closed_reg <= CW'(wb_req.dat);
            `WDK_OFS_OPEN:
               open_reg <= CW'(wb_req.dat);
            default:
               ;
         endcase
      end
   end

   // key capture and restart decision
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         service_reg <= `WDK_SERVICE_RST;
         restart_reg <= 1'b0;
      end
      else
      begin
         restart_reg <= svc_write && !bad_write;
         if (svc_write)
            service_reg <= wb_req.dat[7:0];
      end
   end

   // system reset pulse; stretched so the system sees it
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_cnt_reg <= 4'h0;
         sys_reset_reg <= 1'b0;
         last_cause_reg <= 2'h0;
      end
      else
      begin
         if (bad_write || expired)
         begin
            rst_cnt_reg <= `WDK_RST_PULSE;
            sys_reset_reg <= 1'b1;
            if (expired)
               last_cause_reg <= 2'h3;
            else if (key_ok)
               last_cause_reg <= 2'h2;
            else
               last_cause_reg <= 2'h1;
         end
         else if (rst_cnt_reg > 4'h1)
            rst_cnt_reg <= rst_cnt_reg - 4'h1;
         else
         begin
            rst_cnt_reg <= 4'h0;
            sys_reset_reg <= 1'b0;
         end
      end
   end
endmodule

// >>> testbench/wdk_service_sva.sv
`timescale 1ns/10ps
// port checker; mode bits mirrored from ctrl writes
module wdk_service_chk
#(
   parameter int CW = 32
)
(
   input wire logic clk,
   input wire logic resetn,
   input wdk_pkg::wdk_wb_req_s wb_req,
   input wdk_pkg::wdk_wb_rsp_s wb_rsp,
   input wire logic sys_reset
);
   import wdk_pkg::*;
   logic en; // mirrored enable
   logic win; // mirrored window mode
   logic take; // request taken
   logic svc; // service write taken
   logic cwr; // ctrl write lands
   logic key; // key on lane 0
   assign take = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
   assign svc = take && wb_req.we && wb_req.adr == 4'h0 && wb_req.sel[0];
   assign cwr = wb_rsp.ack && wb_req.we && wb_req.adr == 4'h4;
   assign key = wb_req.dat[7:0] == 8'hA5;
   // mirror lands one edge after the design, so an expiry
   // launched just before a disable is not taken as a fault
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         {win, en} <= 2'h0;
      else if (cwr && wb_req.sel[0])
         {win, en} <= wb_req.dat[1:0];
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence bad_s;
      svc && en && !key && !sys_reset;
   endsequence
   sequence pulse_s;
      sys_reset [*8];
   endsequence
   ack_on_time_a:
   assert property (take |=> wb_rsp.ack) else $error("ack late");
   ack_single_a:
   assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack long");
   wrong_key_a:
   assert property (bad_s |=> pulse_s) else $error("no reset on bad key");
   normal_key_a:
   assert property (svc && en && !win && key && !sys_reset |=> !sys_reset)
      else $error("key refused");
   off_quiet_a:
   assert property (!en && !sys_reset |=> !sys_reset)
      else $error("reset when off");
   pulse_len_a:
   assert property ($rose(sys_reset) |-> pulse_s) else $error("short pulse");
endmodule
bind wdk_service wdk_service_chk #(.CW(CW)) i_wdk_service_chk
(
   .clk(clk),
   .resetn(resetn),
   .wb_req(wb_req),
   .wb_rsp(wb_rsp),
   .sys_reset(sys_reset)
);

// >>> testbench/test_watchdog_service_key_check.sv
`timescale 1ns/10ps
module test_watchdog_service_key_check;
   import wdk_pkg::*;
   logic clk;
   logic resetn;
   wdk_wb_req_s req;
   wdk_wb_rsp_s rsp;
   logic sys_reset;
   logic seen; // sticky: a reset pulse was seen
   logic [15:0] rnd; // lfsr state
   logic [31:0] q; // last read data
   int n_mismatch;
   int n_compared;
   wdk_service i_wdk_service
   (
      .clk(clk),
      .resetn(resetn),
      .wb_req(req),
      .wb_rsp(rsp),
      .sys_reset(sys_reset)
   );
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // pulse is short, so latch it for later reads
   always @(posedge clk)
      if (sys_reset === 1'b1)
         seen <= 1'b1;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input string nm, input logic [3:0] s, input logic [3:0] e);
      n_compared++;
      if (s !== e)
      begin
         $display("BAD %s exp %h seen %h", nm, e, s);
         n_mismatch++;
      end
   endtask
   task complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one classic cycle; holds until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      req <= '{1'b1, 1'b1, w, 4'hF, a, d};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rsp.ack !== 1'b1 && n < 20);
      q = rsp.dat;
      req <= '0;
      if (n >= 20)
      begin
         n_mismatch++;
         complete_run;
      end
   endtask
   // restart in a mode, then poll until open
   task automatic go_open(input logic [1:0] m);
      int n;
      wb(1'b1, 4'h4, 32'h0000_0000);
      wb(1'b1, 4'h4, 32'(m));
      n = 0;
      do
      begin
         wb(1'b0, 4'h0, 32'h0000_0000);
         n++;
      end
      while (q[1:0] !== 2'h2 && n < 12);
      chk("open", {2'h0, q[1:0]}, 4'h2);
      rnd = lfsr(rnd);
      seen <= 1'b0;
   endtask
   initial
   begin
      req = '0;
      resetn = 1'b0;
      seen = 1'b0;
      rnd = 16'h07F9;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      wb(1'b0, 4'h0, 32'h0000_0000);
      chk("idle", {2'h0, q[1:0]}, 4'h0);
      wb(1'b1, 4'h8, 32'h0000_0008);
      wb(1'b1, 4'hC, 32'h0000_0010);
      // key in open, then the key again in closed
      go_open(2'h3);
      wb(1'b1, 4'h0, 32'h0000_00A5);
      wb(1'b0, 4'h0, 32'h0000_0000);
      chk("reclose", {2'h0, q[1:0]}, 4'h1);
      chk("keep", {3'h0, seen}, 4'h0);
      // even the key itself is refused while the window is closed
      wb(1'b1, 4'h0, {rnd, rnd[15:8], 8'hA5});
      wb(1'b0, 4'h0, 32'h0000_0000);
      chk("early", {2'h0, q[3:2]}, 4'h2);
      chk("early_rst", {3'h0, seen}, 4'h1);
      $display("test window done");
      go_open(2'h3);
      wb(1'b1, 4'h0, {rnd, 8'h00, rnd[7:0] == 8'hA5 ? 8'h5A : rnd[7:0]});
      wb(1'b0, 4'h0, 32'h0000_0000);
      chk("badkey", {2'h0, q[3:2]}, 4'h1);
      chk("bad_rst", {3'h0, seen}, 4'h1);
      $display("test wrong key done");
      go_open(2'h1);
      repeat (6)
      begin
         wb(1'b1, 4'h0, 32'h0000_00A5);
         rnd = lfsr(rnd);
         repeat (rnd[1:0]) @(posedge clk);
      end
      chk("served", {3'h0, seen}, 4'h0);
      repeat (40) @(posedge clk);
      wb(1'b0, 4'h0, 32'h0000_0000);
      chk("expire", {2'h0, q[3:2]}, 4'h3);
      chk("exp_rst", {3'h0, seen}, 4'h1);
      $display("test normal done");
      wb(1'b1, 4'h4, 32'h0000_0000);
      // let a pulse from an expiry just before the disable run out
      repeat (10) @(posedge clk);
      seen <= 1'b0;
      wb(1'b1, 4'h0, 32'h0000_0011);
      wb(1'b0, 4'h6, 32'h0000_0000);
      chk("off", {2'h0, q[1:0]}, 4'h0);
      chk("off_rst", {3'h0, seen}, 4'h0);
      $display("test disabled done");
      complete_run;
   end
endmodule
